/* File: common/asc_pkg.sv */
// Shared constants for the converter sequencer control block
package asc_pkg;

  // ****************************************************************
  // Register map (indices; byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_IDX      = 8'h24;
  localparam logic [7:0] REG_RESULT_IDX    = 8'h25;
  localparam logic [7:0] REG_IRQ_STAT_IDX  = 8'h26;
  localparam logic [7:0] REG_IRQ_MASK_IDX  = 8'h27;

  // ****************************************************************
  // Status/control field positions
  // ****************************************************************
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_OSC_BIT  = 6;
  localparam int CTRL_PWR_BIT  = 5;
  localparam int CTRL_CH_LSB   = 0;
  localparam int CTRL_CH_W     = 3;

  // Interrupt status/mask bit positions
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_W         = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]       CTRL_RESET   = 8'h00;
  localparam logic [7:0]       RESULT_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 2'h0;

  // ****************************************************************
  // Conversion timing in converter clock cycles
  // ****************************************************************
  localparam logic [4:0] CONV_LAST   = 5'h1f;  // 32 cycles: 0..31
  localparam logic [4:0] SAMPLE_CNT  = 5'h00;
  localparam logic [1:0] DECIDE_PHASE = 2'h3;  // Bit decided every 4th cycle
  localparam logic [7:0] SAR_FIRST   = 8'h80;

  // Sequencer states
  typedef enum logic [0:0] {
    ASC_IDLE = 1'b0,
    ASC_RUN  = 1'b1
  } asc_state_t;

endpackage

/* File: logic/asc_sar.sv */
// Successive-approximation code register driving the internal DAC
`timescale 1ns/1ps
module asc_sar (
  input  wire logic       clk,       // System clock
  input  wire logic       rst,       // Async reset, active high
  input  wire logic       load,      // Start a new approximation
  input  wire logic       decide,    // Resolve the current trial bit
  input  wire logic       keep,      // Comparator: sample at or above trial
  output logic [7:0]      code,      // Trial code to the DAC
  output logic [7:0]      code_next  // Code after this cycle's decision
);

  logic [7:0] code_reg;
  logic [7:0] trial_reg;
  logic [7:0] trial_next;
  wire  [7:0] resolved;

  // Clear the trial bit when the sample is below, then try the next bit
  assign resolved   = keep ? code_reg : (code_reg & ~trial_reg);
  assign trial_next = load ? asc_pkg::SAR_FIRST : (decide ? {1'b0, trial_reg[7:1]} : trial_reg);
  assign code_next  = load ? asc_pkg::SAR_FIRST : (decide ? (resolved | {1'b0, trial_reg[7:1]}) : code_reg);
  assign code       = code_reg;

  // Code and trial pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_reg  <= 8'h00;
      trial_reg <= 8'h00;
    end else begin
      code_reg  <= code_next;
      trial_reg <= trial_next;
    end
  end

endmodule

/* File: logic/asc_irq.sv */
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module asc_irq (
  input  wire logic                      clk,       // System clock
  input  wire logic                      rst,       // Async reset, active high
  input  wire logic [asc_pkg::IRQ_W-1:0] event_in,  // Event pulses
  input  wire logic                      clr_wr,    // Write to status register
  input  wire logic                      mask_wr,   // Write to mask register
  input  wire logic [asc_pkg::IRQ_W-1:0] wdata,     // Write data
  output logic [asc_pkg::IRQ_W-1:0]      status,    // Sticky status
  output logic [asc_pkg::IRQ_W-1:0]      mask,      // Mask register
  output logic                           irq        // Level interrupt
);

  logic [asc_pkg::IRQ_W-1:0] status_reg;
  logic [asc_pkg::IRQ_W-1:0] mask_reg;
  wire  [asc_pkg::IRQ_W-1:0] clr_bits;

  // An event in the clearing cycle survives: set wins over clear
  assign clr_bits = clr_wr ? wdata : '0;
  assign status   = status_reg;
  assign mask     = mask_reg;
  assign irq      = |(status_reg & mask_reg);

  // Status and mask storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= asc_pkg::IRQ_RESET;
      mask_reg   <= asc_pkg::IRQ_RESET;
    end else begin
      status_reg <= (status_reg & ~clr_bits) | event_in;
      if (mask_wr) begin
        mask_reg <= wdata;
      end
    end
  end

endmodule

/* File: logic/asc_top.sv */
// Converter sequencer control with Wishbone register access
`timescale 1ns/1ps
module asc_top (
  input  wire logic        clk,            // System (CPU) clock, 40 MHz
  input  wire logic        rst,            // Async reset, active high
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data
  output logic [31:0]      wb_dat_o,       // Wishbone read data
  output logic             wb_ack_o,       // Wishbone acknowledge
  input  wire logic        cpu_wait,       // Processor in WAIT mode
  input  wire logic        cpu_stop,       // Processor in STOP mode
  input  wire logic        rc_osc_tick,    // One pulse per RC oscillator cycle
  input  wire logic        cmp_above,      // Sample at or above DAC level
  output logic             rc_osc_enable,  // Run the RC oscillator
  output logic             pump_enable,    // Charge pump and current sources
  output logic             cmp_enable,     // Comparator power
  output logic [2:0]       channel_select, // Analog multiplexer select
  output logic             sample_hold,    // Sample pulse to the hold capacitor
  output logic [7:0]       dac_code,       // Trial code to the internal DAC
  output logic             irq             // Level interrupt
);

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic                    ack_reg;
  logic [31:0]             dat_reg;
  logic [31:0]             dat_next;
  wire                     bus_req;
  wire                     wr_lane;
  wire                     hit_ctrl;
  wire                     hit_result;
  wire                     hit_stat;
  wire                     hit_mask;
  wire                     ctrl_wr;
  wire                     result_rd;

  // Request taken on the first cycle; ack follows one cycle later
  assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_lane    = wb_we_i & wb_sel_i[0];
  assign hit_ctrl   = wb_adr_i[7:2] == asc_pkg::REG_CTRL_IDX[5:0];
  assign hit_result = wb_adr_i[7:2] == asc_pkg::REG_RESULT_IDX[5:0];
  assign hit_stat   = wb_adr_i[7:2] == asc_pkg::REG_IRQ_STAT_IDX[5:0];
  assign hit_mask   = wb_adr_i[7:2] == asc_pkg::REG_IRQ_MASK_IDX[5:0];
  assign ctrl_wr    = bus_req & wr_lane & hit_ctrl;
  assign result_rd  = bus_req & ~wb_we_i & hit_result;
  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = dat_reg;

  // ****************************************************************
  // Control register and converter clock choice
  // ****************************************************************
  logic [7:0]              ctrl_reg;
  wire                     osc_sel;
  wire                     power_on;
  wire                     running_power;
  wire                     conv_step;

  assign osc_sel        = ctrl_reg[asc_pkg::CTRL_OSC_BIT];
  assign power_on       = ctrl_reg[asc_pkg::CTRL_PWR_BIT];
  assign channel_select = ctrl_reg[asc_pkg::CTRL_CH_LSB +: asc_pkg::CTRL_CH_W];
  // WAIT is deliberately not a term here: the converter keeps going
  assign running_power  = power_on & ~cpu_stop;
  assign pump_enable    = running_power;
  assign cmp_enable     = running_power;
  // Oscillator follows power so clearing power stops it when selected
  assign rc_osc_enable  = osc_sel & running_power;
  // RC tick when selected, else every CPU clock; CPU clock must be 1 MHz or more
  assign conv_step      = osc_sel ? rc_osc_tick : 1'b1;

  // Writable control bits; the completion bit lives elsewhere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= asc_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= {1'b0, wb_dat_i[6:5], 2'b00, wb_dat_i[2:0]};
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  asc_pkg::asc_state_t     state_reg;
  asc_pkg::asc_state_t     state_next;
  logic [4:0]              cnt_reg;
  logic [4:0]              cnt_next;
  logic [7:0]              result_reg;
  logic                    done_reg;
  logic [7:0]              sar_next;
  wire                     running;
  wire                     at_sample;
  wire                     decide;
  wire                     conv_end;
  wire                     abort_evt;

  assign running   = state_reg == asc_pkg::ASC_RUN;
  assign at_sample = running & conv_step & (cnt_reg == asc_pkg::SAMPLE_CNT);
  // Hold capacitor sampled once, at cycle zero of each conversion
  assign sample_hold = at_sample;
  // One bit resolved every fourth cycle; the eighth lands on cycle 31
  assign decide    = running & conv_step & (cnt_reg[1:0] == asc_pkg::DECIDE_PHASE);
  assign conv_end  = running & conv_step & (cnt_reg == asc_pkg::CONV_LAST);
  assign abort_evt = running & cpu_stop;

  // Next state: a control write (re)starts unless STOP is high; STOP aborts
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      asc_pkg::ASC_IDLE: begin
        // No software delay after STOP: the wake-up delay already covers settling
        if (ctrl_wr && !cpu_stop) begin
          state_next = asc_pkg::ASC_RUN;
        end
      end
      asc_pkg::ASC_RUN: begin
        if (cpu_stop) begin
          state_next = asc_pkg::ASC_IDLE;
        end
      end
    endcase
  end

  // Cycle count wraps after 31 so conversions run back to back
  assign cnt_next = (ctrl_wr || !running) ? asc_pkg::SAMPLE_CNT :
                    (conv_step ? cnt_reg + 5'h01 : cnt_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= asc_pkg::ASC_IDLE;
      cnt_reg   <= asc_pkg::SAMPLE_CNT;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Trial code register; always-keep comparator saturates at ff
  asc_sar u_sar (
    .clk       (clk),
    .rst       (rst),
    .load      (at_sample),
    .decide    (decide),
    .keep      (cmp_above),
    .code      (dac_code),
    .code_next (sar_next)
  );

  // Result loads with the flag; old result is simply overwritten
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= asc_pkg::RESULT_RESET;
    end else if (conv_end && !ctrl_wr) begin
      result_reg <= sar_next;
    end
  end

  // Completion flag: setting wins over a read in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (conv_end && !ctrl_wr) begin
      done_reg <= 1'b1;
    end else if (ctrl_wr || result_rd) begin
      done_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [asc_pkg::IRQ_W-1:0] irq_status;
  logic [asc_pkg::IRQ_W-1:0] irq_mask;
  wire  [asc_pkg::IRQ_W-1:0] irq_events;
  wire                       irq_stat_wr;
  wire                       irq_mask_wr;

  // Completion event is suppressed when a control write restarts in the same cycle
  assign irq_events  = {abort_evt, conv_end & ~ctrl_wr};
  assign irq_stat_wr = bus_req & wr_lane & hit_stat;
  assign irq_mask_wr = bus_req & wr_lane & hit_mask;

  asc_irq u_irq (
    .clk      (clk),
    .rst      (rst),
    .event_in (irq_events),
    .clr_wr   (irq_stat_wr),
    .mask_wr  (irq_mask_wr),
    .wdata    (wb_dat_i[asc_pkg::IRQ_W-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq)
  );

  // ****************************************************************
  // Read data and acknowledge
  // ****************************************************************
  // Unmapped addresses still ack, with zero data
  always_comb begin
    dat_next = 32'h0000_0000;
    if (hit_ctrl) begin
      dat_next[7:0] = {done_reg, ctrl_reg[6:0]};
    end else if (hit_result) begin
      dat_next[7:0] = result_reg;
    end else if (hit_stat) begin
      dat_next[asc_pkg::IRQ_W-1:0] = irq_status;
    end else if (hit_mask) begin
      dat_next[asc_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_reg <= dat_next;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] since_sample_reg;

  // Helper: CPU clocks since the last sample pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_sample_reg <= 8'h00;
    end else if (at_sample) begin
      since_sample_reg <= 8'h00;
    end else if (since_sample_reg != 8'hff) begin
      since_sample_reg <= since_sample_reg + 8'h01;
    end
  end

  sequence s_request;
    wb_cyc_i && wb_stb_i && !ack_reg;
  endsequence

  sequence s_single_ack;
    ack_reg ##1 !ack_reg;
  endsequence

  bus_ack_a: assert property (@(posedge clk) disable iff (rst)
    s_request |=> s_single_ack)
    else $error("Bus request not answered by a single ack");

  // Helper restarts after the sample cycle, so the 32nd cycle reads 30
  conv_length_a: assert property (@(posedge clk) disable iff (rst)
    conv_end && !osc_sel |-> since_sample_reg == 8'h1e)
    else $error("Conversion did not last 32 cycles");

  sample_once_a: assert property (@(posedge clk) disable iff (rst)
    sample_hold && !ctrl_wr |-> cnt_reg == 5'h00 ##1 !sample_hold)
    else $error("Sample pulse outside conversion start");

  result_load_a: assert property (@(posedge clk) disable iff (rst)
    conv_end && !ctrl_wr |=> done_reg && result_reg == $past(sar_next))
    else $error("Result and completion flag not updated together");

  done_clear_a: assert property (@(posedge clk) disable iff (rst)
    (ctrl_wr || (result_rd && !conv_end)) |=> !done_reg)
    else $error("Completion flag not cleared");

  done_set_a: assert property (@(posedge clk) disable iff (rst)
    $rose(done_reg) |-> $past(conv_end))
    else $error("Completion flag set without a finished conversion");

  back_to_back_a: assert property (@(posedge clk) disable iff (rst)
    conv_end && !cpu_stop && !ctrl_wr |=> running && cnt_reg == 5'h00)
    else $error("Conversions do not continue back to back");

  restart_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> cnt_reg == 5'h00 && channel_select == $past(wb_dat_i[2:0]))
    else $error("Control write did not restart on new channel");

  stop_abort_a: assert property (@(posedge clk) disable iff (rst)
    cpu_stop |-> !pump_enable && !cmp_enable ##1 !running)
    else $error("STOP did not abort conversion");

  rc_off_a: assert property (@(posedge clk) disable iff (rst)
    !power_on |-> !rc_osc_enable && !pump_enable)
    else $error("RC oscillator or pump on while powered off");

  osc_step_a: assert property (@(posedge clk) disable iff (rst)
    running && osc_sel && !rc_osc_tick && !ctrl_wr |=> $stable(cnt_reg))
    else $error("Counter advanced without an RC oscillator tick");

  wait_run_a: assert property (@(posedge clk) disable iff (rst)
    cpu_wait && !cpu_stop && power_on |-> pump_enable && cmp_enable)
    else $error("Converter shut down during WAIT");

  // A mask write in the completion cycle may legally hide the event
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    conv_end && !ctrl_wr && irq_mask[asc_pkg::IRQ_DONE_BIT] && !irq_mask_wr |=> irq)
    else $error("Unmasked completion did not raise interrupt");

  // Write one to clear, unless a completion sets the bit in the same cycle
  irq_clear_a: assert property (@(posedge clk) disable iff (rst)
    irq_stat_wr && wb_dat_i[asc_pkg::IRQ_DONE_BIT] && !(conv_end && !ctrl_wr)
    |=> !irq_status[asc_pkg::IRQ_DONE_BIT])
    else $error("Completion status not cleared by a one");

  // Flag and result move only on their own events
  done_hold_a: assert property (@(posedge clk) disable iff (rst)
    done_reg && !ctrl_wr && !result_rd |=> done_reg)
    else $error("Completion flag dropped without a clearing access");

  result_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(conv_end && !ctrl_wr) |=> $stable(result_reg))
    else $error("Result changed without a finished conversion");

  rc_run_a: assert property (@(posedge clk) disable iff (rst)
    osc_sel && power_on && !cpu_stop |-> rc_osc_enable)
    else $error("RC oscillator off while selected and powered");

endmodule

/* File: bench/asc_analog_model.sv */
// Behavioural analog front end: pin levels, reference points, hold capacitor and comparator
`timescale 1ns/1ps
module asc_analog_model (
  input  wire logic        clk,            // System clock
  input  wire logic        rst,            // Async reset, active high
  input  wire logic [2:0]  channel_select, // Multiplexer select
  input  wire logic        sample_hold,    // Sample pulse
  input  wire logic        cmp_enable,     // Comparator power
  input  wire logic [7:0]  dac_code,       // Trial code from the sequencer
  input  wire logic [31:0] pin_levels,     // Four external pin levels, one byte each
  output logic             cmp_above       // Held sample at or above DAC level
);
  // ****************************************************************
  // Multiplexer and hold capacitor
  // ****************************************************************
  logic [7:0] held_reg;
  logic       junk_reg;
  logic [7:0] level;

  // Pins on codes 0-3; top, bottom, quarter and half of the span on 4-7
  assign level = !channel_select[2] ? pin_levels[8*channel_select +: 8] :
                 !channel_select[1] ? {8{~channel_select[0]}} :
                 {channel_select[0], ~channel_select[0], 6'h00};

  // Sample taken only on the pulse, held for the whole approximation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_reg <= 8'h00;
      junk_reg <= 1'b0;
    end else begin
      junk_reg <= ~junk_reg;
      if (sample_hold) begin
        held_reg <= level;
      end
    end
  end

  // Unpowered comparator gives a changing level, never a stale answer
  assign cmp_above = cmp_enable ? (held_reg >= dac_code) : junk_reg;
endmodule

/* File: bench/test_adc_sequencer_control.sv */
// Self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module test_adc_sequencer_control;
  localparam logic [7:0] A_CTL = {asc_pkg::REG_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] A_RES = {asc_pkg::REG_RESULT_IDX[5:0], 2'b00};
  localparam logic [7:0] A_STA = {asc_pkg::REG_IRQ_STAT_IDX[5:0], 2'b00};
  localparam logic [7:0] A_MSK = {asc_pkg::REG_IRQ_MASK_IDX[5:0], 2'b00};
  logic        clk, rst, cyc, stb, we, cpu_wait, cpu_stop, tick, cmp_above;
  logic        ack, rc_en, pump_en, cmp_en, sh, irq, gap_on;
  logic [2:0]  chsel;
  logic [3:0]  sel;
  logic [7:0]  adr, dac;
  logic [31:0] wdat, rdo, pins, lfsr;
  logic [31:0] exp_q[$];
  int          n_mismatch, tests_run, cycles, gap;

  asc_top dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .cpu_wait(cpu_wait),
    .cpu_stop(cpu_stop), .rc_osc_tick(tick), .cmp_above(cmp_above), .rc_osc_enable(rc_en),
    .pump_enable(pump_en), .cmp_enable(cmp_en), .channel_select(chsel), .sample_hold(sh),
    .dac_code(dac), .irq(irq));

  asc_analog_model far_u (.clk(clk), .rst(rst), .channel_select(chsel), .sample_hold(sh),
    .cmp_enable(cmp_en), .dac_code(dac), .pin_levels(pins), .cmp_above(cmp_above));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Level that an ideal approximation of each channel must return
  function automatic logic [7:0] lvl(input logic [2:0] c, input logic [31:0] p);
    if (!c[2]) return p[8*c +: 8];
    if (!c[1]) return {8{~c[0]}};
    return {c[0], ~c[0], 6'h00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Classic single cycle; the request stands until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'h1;
    do @(posedge clk); while (ack !== 1'b1);
    if (w && a == A_CTL && !d[6]) check("start pulse", 32'(sh), 32'h1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 80) begin
      @(posedge clk);
      i++;
    end
    check("irq", 32'(irq), 32'h1);
  endtask

  // ****************************************************************
  // Clock, watcher and timeout
  // ****************************************************************
  // CPU clock well above 1 MHz, so software may leave the converter on it
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Read data is compared with the oldest note; sample pulses are timed
  always @(posedge clk) begin
    cycles++;
    gap++;
    if (cycles > 6000) begin
      n_mismatch++;
      print_verdict();
    end
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) check("read data", rdo, exp_q.pop_front());
    if (sh === 1'b1) begin
      if (gap_on) check("period", 32'(gap), 32'd32);
      gap = 0;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
    cpu_wait = 1'b0; cpu_stop = 1'b0; tick = 1'b0; pins = 32'h0; lfsr = 32'h4ce53a6e;
    gap_on = 1'b0; n_mismatch = 0; tests_run = 0; cycles = 0; gap = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd(A_CTL, 32'h0);
    rd(A_RES, 32'h0);
    rd(A_STA, 32'h0);
    rd(A_MSK, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, A_MSK, 32'h1);
    // Every channel code with random pin levels, WAIT toggled along
    for (int ch = 0; ch < 8; ch++) begin
      lfsr = nxt(lfsr);
      pins <= lfsr;
      cpu_wait <= ch[0];
      bus(1'b1, A_CTL, {lfsr[31:8], 8'h20 | 8'(ch)});
      bus(1'b1, A_STA, 32'h1);
      wait_irq();
      rd(A_CTL, 32'ha0 | 32'(ch));
      rd(A_RES, 32'(lvl(3'(ch), lfsr)));
      rd(A_CTL, 32'h20 | 32'(ch));
    end
    // Back-to-back repeats overwrite a result never read
    lfsr = nxt(lfsr);
    pins <= lfsr;
    bus(1'b1, A_CTL, 32'h21);
    bus(1'b1, A_STA, 32'h1);
    wait_irq();
    gap_on = 1'b1;
    lfsr = nxt(lfsr);
    pins <= lfsr;
    repeat (2) begin
      bus(1'b1, A_STA, 32'h1);
      wait_irq();
    end
    gap_on = 1'b0;
    rd(A_RES, 32'(lfsr[15:8]));
    // Masked completion keeps the line low but the status bit set
    bus(1'b1, A_MSK, 32'h0);
    bus(1'b1, A_STA, 32'h1);
    repeat (40) @(posedge clk);
    check("masked irq", 32'(irq), 32'h0);
    rd(A_STA, 32'h1);
    bus(1'b1, A_MSK, 32'h1);
    check("unmasked irq", 32'(irq), 32'h1);
    // Restart in mid-conversion discards the partial result
    bus(1'b1, A_CTL, 32'h22);
    repeat (10) @(posedge clk);
    bus(1'b1, A_CTL, 32'h24);
    bus(1'b1, A_STA, 32'h1);
    repeat (25) @(posedge clk);
    check("early irq", 32'(irq), 32'h0);
    wait_irq();
    rd(A_RES, 32'hff);
    // RC clock: the count advances only on ticks, 32 of them
    tick <= 1'b0;
    bus(1'b1, A_CTL, 32'h65);
    bus(1'b1, A_STA, 32'h1);
    check("rc enable", 32'(rc_en), 32'h1);
    repeat (60) @(posedge clk);
    check("stalled irq", 32'(irq), 32'h0);
    repeat (62) @(posedge clk) tick <= ~tick;
    repeat (2) @(posedge clk);
    check("31 ticks", 32'(irq), 32'h0);
    repeat (8) @(posedge clk) tick <= ~tick;
    repeat (2) @(posedge clk);
    check("32 ticks", 32'(irq), 32'h1);
    tick <= 1'b0;
    rd(A_RES, 32'h0);
    bus(1'b1, A_CTL, 32'h40);
    check("rc off", 32'({rc_en, pump_en}), 32'h0);
    bus(1'b1, A_CTL, 32'h23);
    check("power on", 32'({rc_en, pump_en, cmp_en}), 32'h3);
    // STOP aborts and powers down; restart needs no delay
    bus(1'b1, A_STA, 32'h3);
    repeat (5) @(posedge clk);
    cpu_stop <= 1'b1;
    repeat (2) @(posedge clk);
    check("stop power", 32'({pump_en, cmp_en}), 32'h0);
    repeat (40) @(posedge clk);
    rd(A_STA, 32'h2);
    cpu_stop <= 1'b0;
    bus(1'b1, A_STA, 32'h3);
    bus(1'b1, A_CTL, 32'h26);
    bus(1'b1, A_STA, 32'h1);
    wait_irq();
    rd(A_RES, 32'h40);
    bus(1'b1, A_RES, 32'h55);
    rd(A_RES, 32'h40);
    print_verdict();
  end
endmodule
